// [design/usb_iso_suspend.sv]
// Isochronous endpoint buffer control, suspend/resume handling and AXI4-Lite register slave
// What this block does
// - Iso transactions have no handshake, no retry
// - Iso data packets always carry DATA0
// - Transfer kind 10 selects isochronous behaviour
// - Direction toggle selects the peripheral's buffer slot
// - Completion sets done flag; iso completion also flips toggle
// - Completion leaves status pair unchanged
// - CRC error or overrun still completes iso OUT
// - OUT CRC error also sets error flag
// - Three missed frame markers raise sleep flag
// - Bus reset detected while suspended too
// - Force sleep stops missed-marker suspend checking
// - Low power bit idles transceiver, keeps wake
// - Bus activity clears low power asynchronously
// - Idle ends reset; reset flag then set
// - Missed-marker events every 1ms
// - Masked flags drive one interrupt request
`timescale 1ns/1ns
module usb_iso_suspend #(
  parameter int FRAME_CYCLES = usb_iso_pkg::FRAME_CYCLES
) (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // AXI4-Lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Packet engine side
  input  wire usb_iso_pkg::xact_t xact,
  input  wire logic               frame_marker_seen,
  output logic                    iso_mode,
  output logic                    handshake_enable,
  output logic                    pid_data1,
  output logic                    rx_buffer_slot,
  output logic                    tx_buffer_slot,
  output logic                    rx_enabled,
  output logic                    tx_enabled,
  output logic                    bus_reset_active,
  // Bus data lines and transceiver
  input  wire logic               line_plus_pin,
  input  wire logic               line_minus_pin,
  output logic                    line_plus_out,
  output logic                    line_minus_out,
  output logic                    line_oe_n,
  output logic                    xcvr_low_power,
  output logic                    xcvr_power_down,
  output logic                    irq
);

  typedef struct packed {
    logic [1:0]               plus_sync;
    logic [1:0]               minus_sync;
    logic [1:0]               plus_meta;
    logic [1:0]               line_q;
    usb_iso_pkg::link_state_t link;
    logic [31:0]              frame_cnt;
    logic [1:0]               missed_cnt;
    logic [15:0]              se0_cnt;
    logic                     wake_armed;
    logic [15:0]              ctrl;
    logic [15:0]              status;
    logic                     rx_done;
    logic                     rx_toggle;
    logic [1:0]               rx_stat;
    logic [1:0]               kind;
    logic                     tx_done;
    logic                     tx_toggle;
    logic [1:0]               tx_stat;
    logic                     aw_held;
    logic [7:0]               aw_addr;
    logic                     w_held;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic   low_power_ff;
  logic   lp_wake_async;
  logic   do_write;
  logic   ctrl_wr;
  logic [15:0] wr16;

  assign do_write = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
  assign wr16     = st_ff.w_data[15:0];
  assign ctrl_wr  = do_write && st_ff.aw_addr == usb_iso_pkg::OFF_MAIN_CTRL && st_ff.w_strb[0];

  // Raw line activity while suspended, not from our own resume drive
  assign lp_wake_async = (st_ff.link == usb_iso_pkg::LINK_SLEEP) && !st_ff.ctrl[usb_iso_pkg::CTRL_RESUME_REQ]
                         && !(line_plus_pin && !line_minus_pin);

  // Low power bit: cleared without a clock by bus activity
  always_ff @(posedge clk_sys or posedge lp_wake_async) begin
    if (lp_wake_async) begin
      low_power_ff <= 1'b0;
    end else if (!rstn) begin
      low_power_ff <= 1'b0;
    end else if (ctrl_wr) begin
      low_power_ff <= wr16[usb_iso_pkg::CTRL_LOW_POWER];
    end
  end

  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic        frame_tick;
    logic        is_iso;
    logic [1:0]  line_now;
    rd         = 32'h0000_0000;
    hit        = 1'b1;
    nxt_st     = st_ff;
    is_iso     = st_ff.kind == usb_iso_pkg::KIND_ISO;
    line_now   = st_ff.line_q;
    frame_tick = 1'b0;

    // Line synchronisers: change taken once stages two and three agree
    nxt_st.plus_meta  = {line_plus_pin, line_minus_pin};
    nxt_st.plus_sync  = st_ff.plus_meta;
    nxt_st.minus_sync = st_ff.plus_sync;
    if (st_ff.plus_sync == st_ff.minus_sync) begin
      nxt_st.line_q = st_ff.minus_sync;
    end

    // Software clears status bits by writing zero; event sets below win
    if (do_write && st_ff.aw_addr == usb_iso_pkg::OFF_INT_STATUS && st_ff.w_strb[1]) begin
      nxt_st.status = st_ff.status & (wr16 | ~usb_iso_pkg::STAT_CLEARABLE);
    end

    // Frame marker timer
    if (frame_marker_seen) begin
      nxt_st.frame_cnt  = 32'h0000_0000;
      nxt_st.missed_cnt = 2'h0;
    end else if (st_ff.frame_cnt >= 32'(FRAME_CYCLES - 1)) begin
      nxt_st.frame_cnt = 32'h0000_0000;
      frame_tick       = 1'b1;
    end else begin
      nxt_st.frame_cnt = st_ff.frame_cnt + 32'h0000_0001;
    end
    if (frame_tick) begin
      nxt_st.status[usb_iso_pkg::STAT_MISSED] = 1'b1;
    end

    // Link state handling
    if (line_now == usb_iso_pkg::LINE_SE0) begin
      if (st_ff.se0_cnt < 16'(usb_iso_pkg::RESET_DETECT_CYC)) begin
        nxt_st.se0_cnt = st_ff.se0_cnt + 16'h0001;
      end
    end else begin
      nxt_st.se0_cnt = 16'h0000;
    end
    case (st_ff.link)
      usb_iso_pkg::LINK_ACTIVE: begin
        if (st_ff.se0_cnt >= 16'(usb_iso_pkg::RESET_DETECT_CYC) || st_ff.ctrl[usb_iso_pkg::CTRL_FORCE_RESET]) begin
          nxt_st.link = usb_iso_pkg::LINK_RESET;
        end else if (st_ff.ctrl[usb_iso_pkg::CTRL_FORCE_SLEEP]) begin
          nxt_st.link = usb_iso_pkg::LINK_SLEEP;
        end else if (frame_tick && !frame_marker_seen) begin
          nxt_st.missed_cnt = st_ff.missed_cnt + 2'h1;
          if (st_ff.missed_cnt + 2'h1 == usb_iso_pkg::MISSED_LIMIT) begin
            nxt_st.status[usb_iso_pkg::STAT_SLEEP] = 1'b1;
            nxt_st.missed_cnt = 2'h0;
          end
        end
      end
      usb_iso_pkg::LINK_SLEEP: begin
        nxt_st.missed_cnt = 2'h0;
        if (line_now != usb_iso_pkg::LINE_IDLE && !st_ff.ctrl[usb_iso_pkg::CTRL_RESUME_REQ] && st_ff.wake_armed) begin
          nxt_st.status[usb_iso_pkg::STAT_WAKE] = 1'b1;
          nxt_st.wake_armed = 1'b0;
        end
        if (st_ff.se0_cnt >= 16'(usb_iso_pkg::RESET_DETECT_CYC)) begin
          nxt_st.link = usb_iso_pkg::LINK_RESET;
        end else if (!st_ff.ctrl[usb_iso_pkg::CTRL_FORCE_SLEEP]) begin
          nxt_st.link = usb_iso_pkg::LINK_ACTIVE;
        end
      end
      usb_iso_pkg::LINK_RESET: begin
        nxt_st.missed_cnt = 2'h0;
        if (line_now == usb_iso_pkg::LINE_IDLE && !st_ff.ctrl[usb_iso_pkg::CTRL_FORCE_RESET]) begin
          nxt_st.status[usb_iso_pkg::STAT_RESET] = 1'b1;
          nxt_st.link = usb_iso_pkg::LINK_ACTIVE;
        end
      end
      default: begin
        nxt_st.link = usb_iso_pkg::LINK_ACTIVE;
      end
    endcase
    if (st_ff.link != usb_iso_pkg::LINK_SLEEP) begin
      nxt_st.wake_armed = 1'b1;
    end

    // Register writes
    if (ctrl_wr) begin
      nxt_st.ctrl = wr16 & 16'hFF1F;
    end
    if (do_write && st_ff.aw_addr == usb_iso_pkg::OFF_ENDPOINT) begin
      if (st_ff.w_strb[1]) begin
        nxt_st.rx_done   = st_ff.rx_done & wr16[usb_iso_pkg::EP_RX_DONE];
        nxt_st.rx_toggle = st_ff.rx_toggle ^ wr16[usb_iso_pkg::EP_RX_TOGGLE];
        nxt_st.rx_stat   = wr16[usb_iso_pkg::EP_RX_STAT +: 2];
        nxt_st.kind[1]   = wr16[usb_iso_pkg::EP_KIND + 1];
      end
      if (st_ff.w_strb[0]) begin
        nxt_st.kind[0]   = wr16[usb_iso_pkg::EP_KIND];
        nxt_st.tx_done   = st_ff.tx_done & wr16[usb_iso_pkg::EP_TX_DONE];
        nxt_st.tx_toggle = st_ff.tx_toggle ^ wr16[usb_iso_pkg::EP_TX_TOGGLE];
        nxt_st.tx_stat   = wr16[usb_iso_pkg::EP_TX_STAT +: 2];
      end
    end

    // Transaction completion; set wins over a same-cycle clear
    if (xact.done && st_ff.link == usb_iso_pkg::LINK_ACTIVE) begin
      if (xact.is_in && st_ff.tx_stat == usb_iso_pkg::STAT_VALID) begin
        nxt_st.tx_done = 1'b1;
        if (is_iso) begin
          nxt_st.tx_toggle = nxt_st.tx_toggle ^ 1'b1;
        end
      end else if (!xact.is_in && st_ff.rx_stat == usb_iso_pkg::STAT_VALID) begin
        if (is_iso || !(xact.crc_err || xact.overrun)) begin
          nxt_st.rx_done = 1'b1;
          if (is_iso) begin
            nxt_st.rx_toggle = nxt_st.rx_toggle ^ 1'b1;
          end
        end
        if (xact.crc_err) begin
          nxt_st.status[usb_iso_pkg::STAT_ERR] = 1'b1;
        end
      end
    end
    nxt_st.status[usb_iso_pkg::STAT_DONE] = nxt_st.rx_done | nxt_st.tx_done;

    // AXI write channels, taken in either order
    if (s_axi_awvalid && !st_ff.aw_held) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !st_ff.w_held) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = (st_ff.aw_addr == usb_iso_pkg::OFF_LINE_STATE || st_ff.aw_addr > usb_iso_pkg::OFF_ENDPOINT)
                       ? usb_iso_pkg::RESP_SLVERR : usb_iso_pkg::RESP_OKAY;
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // AXI read
    case ({s_axi_araddr[7:2], 2'b00})
      usb_iso_pkg::OFF_MAIN_CTRL: begin
        rd = {16'h0000, st_ff.ctrl};
        rd[usb_iso_pkg::CTRL_LOW_POWER] = low_power_ff;
      end
      usb_iso_pkg::OFF_INT_STATUS: begin
        rd = {16'h0000, st_ff.status};
      end
      usb_iso_pkg::OFF_LINE_STATE: begin
        rd[usb_iso_pkg::LINE_PLUS]  = st_ff.line_q[1];
        rd[usb_iso_pkg::LINE_MINUS] = st_ff.line_q[0];
      end
      usb_iso_pkg::OFF_ENDPOINT: begin
        rd[usb_iso_pkg::EP_RX_DONE]        = st_ff.rx_done;
        rd[usb_iso_pkg::EP_RX_TOGGLE]      = st_ff.rx_toggle;
        rd[usb_iso_pkg::EP_RX_STAT +: 2]   = st_ff.rx_stat;
        rd[usb_iso_pkg::EP_KIND +: 2]      = st_ff.kind;
        rd[usb_iso_pkg::EP_TX_DONE]        = st_ff.tx_done;
        rd[usb_iso_pkg::EP_TX_TOGGLE]      = st_ff.tx_toggle;
        rd[usb_iso_pkg::EP_TX_STAT +: 2]   = st_ff.tx_stat;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (s_axi_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd;
      nxt_st.rresp  = hit ? usb_iso_pkg::RESP_OKAY : usb_iso_pkg::RESP_SLVERR;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_ff      <= '0;
      st_ff.link <= usb_iso_pkg::LINK_ACTIVE;
      st_ff.ctrl <= usb_iso_pkg::CTRL_RESET_VALUE;
      st_ff.plus_meta  <= usb_iso_pkg::LINE_IDLE;
      st_ff.plus_sync  <= usb_iso_pkg::LINE_IDLE;
      st_ff.minus_sync <= usb_iso_pkg::LINE_IDLE;
      st_ff.line_q     <= usb_iso_pkg::LINE_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = !st_ff.aw_held;
  assign s_axi_wready  = !st_ff.w_held;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;

  assign iso_mode         = st_ff.kind == usb_iso_pkg::KIND_ISO;
  assign handshake_enable = !iso_mode;
  assign pid_data1        = iso_mode ? 1'b0 : (st_ff.kind[0] ? st_ff.tx_toggle : st_ff.rx_toggle);
  assign rx_buffer_slot   = st_ff.rx_toggle;
  assign tx_buffer_slot   = st_ff.tx_toggle;
  assign rx_enabled       = st_ff.rx_stat == usb_iso_pkg::STAT_VALID;
  assign tx_enabled       = st_ff.tx_stat == usb_iso_pkg::STAT_VALID;
  assign bus_reset_active = st_ff.link == usb_iso_pkg::LINK_RESET;

  // Resume signalling: K state is minus high, plus low
  assign line_plus_out   = 1'b0;
  assign line_minus_out  = st_ff.ctrl[usb_iso_pkg::CTRL_RESUME_REQ];
  assign line_oe_n       = !st_ff.ctrl[usb_iso_pkg::CTRL_RESUME_REQ];
  assign xcvr_low_power  = low_power_ff;
  assign xcvr_power_down = st_ff.ctrl[usb_iso_pkg::CTRL_POWER_DOWN];

  assign irq = |(st_ff.status & st_ff.ctrl & 16'hBD00);

endmodule : usb_iso_suspend

// [inc/usb_iso_pkg.sv]
// Package: register map, field positions, timing and carrier types for the iso/suspend block
package usb_iso_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_MAIN_CTRL  = 8'h00;
  localparam logic [7:0] OFF_INT_STATUS = 8'h04;
  localparam logic [7:0] OFF_LINE_STATE = 8'h08;
  localparam logic [7:0] OFF_ENDPOINT   = 8'h0C;

  // Main control register fields
  localparam int CTRL_DONE_MASK   = 15;
  localparam int CTRL_ERR_MASK    = 13;
  localparam int CTRL_WAKE_MASK   = 12;
  localparam int CTRL_SLEEP_MASK  = 11;
  localparam int CTRL_RESET_MASK  = 10;
  localparam int CTRL_MISSED_MASK = 8;
  localparam int CTRL_RESUME_REQ  = 4;
  localparam int CTRL_FORCE_SLEEP = 3;
  localparam int CTRL_LOW_POWER   = 2;
  localparam int CTRL_POWER_DOWN  = 1;
  localparam int CTRL_FORCE_RESET = 0;
  localparam logic [15:0] CTRL_RESET_VALUE = 16'h0003;

  // Interrupt status register fields
  localparam int STAT_DONE   = 15;
  localparam int STAT_ERR    = 13;
  localparam int STAT_WAKE   = 12;
  localparam int STAT_SLEEP  = 11;
  localparam int STAT_RESET  = 10;
  localparam int STAT_MISSED = 8;
  localparam logic [15:0] STAT_CLEARABLE = 16'h3D00;

  // Line state register fields
  localparam int LINE_PLUS  = 15;
  localparam int LINE_MINUS = 14;

  // Endpoint register fields
  localparam int EP_RX_DONE   = 15;
  localparam int EP_RX_TOGGLE = 14;
  localparam int EP_RX_STAT   = 12;
  localparam int EP_KIND      = 9;
  localparam int EP_TX_DONE   = 7;
  localparam int EP_TX_TOGGLE = 6;
  localparam int EP_TX_STAT   = 4;
  localparam logic [1:0] KIND_ISO    = 2'h2;
  localparam logic [1:0] STAT_VALID  = 2'h3;
  localparam logic [1:0] LINE_IDLE   = 2'h2;
  localparam logic [1:0] LINE_SE0    = 2'h0;

  // Timing
  localparam int CLK_MHZ            = 100;
  localparam int FRAME_PERIOD_US    = 1000;
  localparam int FRAME_CYCLES       = FRAME_PERIOD_US * CLK_MHZ;
  localparam int RESET_DETECT_NS    = 2500;
  localparam int RESET_DETECT_CYC   = (RESET_DETECT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] MISSED_LIMIT = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Link states
  typedef enum logic [2:0] {
    LINK_ACTIVE = 3'h1,
    LINK_SLEEP  = 3'h2,
    LINK_RESET  = 3'h4
  } link_state_t;

  // Transaction report from the packet engine
  typedef struct packed {
    logic done;
    logic is_in;
    logic crc_err;
    logic overrun;
  } xact_t;

endpackage : usb_iso_pkg

// [testbench/usb_iso_suspend_asserts.sv]
// Port checker for the iso endpoint and suspend block
`timescale 1ns/1ns
module usb_iso_suspend_asserts (
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire usb_iso_pkg::xact_t xact,
  input wire logic               iso_mode,
  input wire logic               handshake_enable,
  input wire logic               pid_data1,
  input wire logic               rx_buffer_slot,
  input wire logic               tx_buffer_slot,
  input wire logic               rx_enabled,
  input wire logic               tx_enabled,
  input wire logic               bus_reset_active,
  input wire logic               line_plus_out,
  input wire logic               line_minus_out,
  input wire logic               line_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  iso_no_hs_a: assert property (iso_mode |-> !handshake_enable) else $error("handshake on iso");
  iso_data0_a: assert property (iso_mode |-> !pid_data1) else $error("iso pid not data0");
  rx_swap_a: assert property (xact.done && !xact.is_in && iso_mode && rx_enabled && !bus_reset_active
    |=> rx_buffer_slot != $past(rx_buffer_slot)) else $error("rx slot not swapped");
  tx_swap_a: assert property (xact.done && xact.is_in && iso_mode && tx_enabled && !bus_reset_active
    |=> tx_buffer_slot != $past(tx_buffer_slot)) else $error("tx slot not swapped");
  slot_cause_a: assert property ($changed(rx_buffer_slot) && !bus_reset_active && !$past(bus_reset_active)
    |-> $past(xact.done) || $rose(s_axi_bvalid)) else $error("rx slot moved alone");
  stat_keep_a: assert property (xact.done && !bus_reset_active
    |=> $stable({rx_enabled, tx_enabled}) || $rose(s_axi_bvalid)) else $error("status pair moved");
  k_state_a: assert property (!line_oe_n |-> line_minus_out && !line_plus_out) else $error("bad resume drive");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready with rvalid");
endmodule : usb_iso_suspend_asserts

bind usb_iso_suspend usb_iso_suspend_asserts i_usb_iso_suspend_asserts (.*);

// [testbench/usb_host_model.sv]
// Host-side model: frame markers, iso packets and bus line states
`timescale 1ns/1ns
module usb_host_model #(
  parameter int FRAME_CYCLES = 200
) (
  input  wire logic          clk_sys,
  input  wire logic          sof_on,
  input  wire logic          line_oe_n,
  input  wire logic          line_plus_out,
  input  wire logic          line_minus_out,
  output usb_iso_pkg::xact_t xact,
  output logic               frame_marker_seen,
  output logic               line_plus_pin,
  output logic               line_minus_pin
);
  int         frame_cnt_ff = 0;
  logic [1:0] host_line_ff = usb_iso_pkg::LINE_IDLE;

  initial xact = '0;
  initial frame_marker_seen = 1'b0;

  // One marker per frame while the bus is alive
  always @(posedge clk_sys) begin
    frame_cnt_ff <= (frame_cnt_ff == FRAME_CYCLES - 1) ? 0 : frame_cnt_ff + 1;
    frame_marker_seen <= sof_on && (frame_cnt_ff == 0);
  end

  // Device drives the wire only while signalling resume
  assign line_plus_pin  = line_oe_n ? host_line_ff[1] : line_plus_out;
  assign line_minus_pin = line_oe_n ? host_line_ff[0] : line_minus_out;

  // One data packet, DATA0, no handshake awaited
  task automatic send_pkt(input logic is_in, input logic crc, input logic ovr);
    @(posedge clk_sys);
    xact <= '{done: 1'b1, is_in: is_in, crc_err: crc, overrun: ovr};
    @(posedge clk_sys);
    xact <= '0;
  endtask : send_pkt

  // Host drives a bus line state: K to wake, SE0 for reset, idle to end them
  task automatic set_line(input logic [1:0] v);
    @(posedge clk_sys);
    host_line_ff <= v;
  endtask : set_line
endmodule : usb_host_model

// [testbench/tb_top.sv]
// Self-checking bench for the iso endpoint and suspend block
`timescale 1ns/1ns
module tb_top;
  localparam int FC = 200;
  logic               clk_sys = 1'b0;
  logic               rstn = 1'b0;
  logic [7:0]         s_axi_awaddr = '0;
  logic [7:0]         s_axi_araddr = '0;
  logic [31:0]        s_axi_wdata = '0;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_rready = 1'b0;
  logic               sof_on = 1'b1;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp, resp;
  logic [31:0]        s_axi_rdata, rd;
  usb_iso_pkg::xact_t xact;
  logic               frame_marker_seen, line_plus_pin, line_minus_pin, exp_slot;
  logic               iso_mode, handshake_enable, pid_data1, rx_buffer_slot, tx_buffer_slot;
  logic               rx_enabled, tx_enabled, bus_reset_active, line_plus_out, line_minus_out;
  logic               line_oe_n, xcvr_low_power, xcvr_power_down, irq;
  int                 bad_count = 0;
  int                 checks = 0;

  always #5 clk_sys = ~clk_sys;

  usb_iso_suspend #(.FRAME_CYCLES(FC)) i_usb_iso_suspend (.*);
  usb_host_model #(.FRAME_CYCLES(FC - 8)) i_usb_host_model (.*);

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rd, e);
    chk({30'h0, resp}, (a > 8'h0C) ? 32'h2 : 32'h0);
  endtask : rdc

  initial begin
    #200000;
    bad_count++;
    finish_test;
  end

  initial begin
    cyc(20);
    rstn <= 1'b1;
    rdc(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0000_0003);
    chk({bus_reset_active, xcvr_power_down}, 2'b11);
    wr(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0, 2'h0);
    cyc(8);
    chk({bus_reset_active, xcvr_power_down}, 2'b00);
    rdc(usb_iso_pkg::OFF_INT_STATUS, 32'h0000_0400);
    wr(usb_iso_pkg::OFF_INT_STATUS, 32'h0, 2'h0);
    $display("test reset done");
    wr(usb_iso_pkg::OFF_ENDPOINT, 32'h0000_3400, 2'h0);
    chk({iso_mode, handshake_enable, pid_data1, rx_enabled, rx_buffer_slot}, 5'b10010);
    wr(usb_iso_pkg::OFF_ENDPOINT, 32'h0000_7400, 2'h0);
    exp_slot = 1'b1;
    chk(rx_buffer_slot, exp_slot);
    for (int k = 0; k < 3; k++) begin
      i_usb_host_model.send_pkt(1'b0, k == 1, k == 2);
      cyc(2);
      exp_slot = !exp_slot;
      chk(rx_buffer_slot, exp_slot);
      rdc(usb_iso_pkg::OFF_ENDPOINT, {16'h0, 1'b1, exp_slot, 14'h3400});
      rdc(usb_iso_pkg::OFF_INT_STATUS, {16'h0, 2'b10, k == 1, 13'h0});
      wr(usb_iso_pkg::OFF_ENDPOINT, 32'h0000_3400, 2'h0);
      wr(usb_iso_pkg::OFF_INT_STATUS, 32'h0, 2'h0);
    end
    wr(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0000_8000, 2'h0);
    chk(irq, 0);
    i_usb_host_model.send_pkt(1'b0, 1'b0, 1'b0);
    cyc(2);
    exp_slot = !exp_slot;
    chk(irq, 1);
    wr(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0, 2'h0);
    chk(irq, 0);
    wr(usb_iso_pkg::OFF_ENDPOINT, 32'h0000_0430, 2'h0);
    i_usb_host_model.send_pkt(1'b1, 1'b0, 1'b0);
    cyc(2);
    chk({tx_enabled, rx_enabled, tx_buffer_slot}, 3'b101);
    rdc(usb_iso_pkg::OFF_ENDPOINT, {16'h0, 1'b0, exp_slot, 14'h04F0});
    wr(usb_iso_pkg::OFF_ENDPOINT, 32'h0000_0430, 2'h0);
    wr(usb_iso_pkg::OFF_INT_STATUS, 32'h0, 2'h0);
    $display("test iso done");
    sof_on <= 1'b0;
    cyc(2 * FC - 10);
    rdc(usb_iso_pkg::OFF_INT_STATUS, 32'h0000_0100);
    cyc(FC + 20);
    rdc(usb_iso_pkg::OFF_INT_STATUS, 32'h0000_0900);
    wr(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0000_0008, 2'h0);
    wr(usb_iso_pkg::OFF_INT_STATUS, 32'h0, 2'h0);
    cyc(2 * FC);
    rdc(usb_iso_pkg::OFF_INT_STATUS, 32'h0000_0100);
    wr(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0000_000C, 2'h0);
    chk(xcvr_low_power, 1);
    i_usb_host_model.set_line(2'b01);
    cyc(6);
    chk(xcvr_low_power, 0);
    rdc(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0000_0008);
    rdc(usb_iso_pkg::OFF_LINE_STATE, 32'h0000_4000);
    rdc(usb_iso_pkg::OFF_INT_STATUS, 32'h0000_1100);
    i_usb_host_model.set_line(2'b00);
    wr(usb_iso_pkg::OFF_INT_STATUS, 32'h0, 2'h0);
    cyc(usb_iso_pkg::RESET_DETECT_CYC + 10);
    chk(bus_reset_active, 1);
    rdc(usb_iso_pkg::OFF_LINE_STATE, 32'h0);
    i_usb_host_model.set_line(usb_iso_pkg::LINE_IDLE);
    cyc(8);
    chk(bus_reset_active, 0);
    rdc(usb_iso_pkg::OFF_INT_STATUS, 32'h0000_0500);
    $display("test suspend done");
    wr(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0000_0008, 2'h0);
    wr(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0000_0018, 2'h0);
    chk({line_oe_n, line_plus_out, line_minus_out}, 3'b001);
    cyc(FC);
    rdc(usb_iso_pkg::OFF_LINE_STATE, 32'h0000_4000);
    wr(usb_iso_pkg::OFF_MAIN_CTRL, 32'h0000_0008, 2'h0);
    chk(line_oe_n, 1);
    wr(8'h10, 32'h0000_FFFF, 2'h2);
    rdc(8'h10, 32'h0);
    wr(usb_iso_pkg::OFF_LINE_STATE, 32'h0000_FFFF, 2'h2);
    $display("test wakeup done");
    finish_test;
  end
endmodule : tb_top
